//--- rtl/sensor_hub_pkg.sv
// constants, field layout and carrier struct of the hub config bank
// assumes one AXI4-Lite slave, byte address = 4 * register index
package sensor_hub_pkg;
  // register indices
  localparam logic [3:0] IDX_STATUS   = 4'h0;
  localparam logic [3:0] IDX_HUB_CTRL = 4'h1;
  localparam logic [3:0] IDX_S2_REG   = 4'h6;
  localparam logic [3:0] IDX_S2_CFG   = 4'h7;
  localparam logic [3:0] IDX_S3_ADDR  = 4'h8;
  localparam logic [3:0] IDX_S3_REG   = 4'h9;
  localparam logic [3:0] IDX_S3_CFG   = 4'ha;
  localparam logic [3:0] IDX_S4_ADDR  = 4'hb;
  localparam logic [3:0] IDX_S4_REG   = 4'hc;
  localparam logic [3:0] IDX_S4_CFG   = 4'hd;
  localparam logic [3:0] IDX_S1_BYTE  = 4'he;
  // field positions
  localparam int unsigned IDX_LSB      = 2;
  localparam int unsigned CFG_RATE_LSB = 6;
  localparam int unsigned ADDR_EN_BIT  = 0;
  localparam int unsigned ADDR_LSB     = 1;
  localparam int unsigned CTRL_READ    = 0;
  localparam int unsigned CTRL_SRC     = 3;
  localparam int unsigned CTRL_USED    = 4;
  // reset value and bus answers
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // configuration handed to the hub engine
  typedef struct packed {
    logic [6:0] sensor3_target_addr;
    logic [6:0] sensor4_target_addr;
    logic [7:0] sensor2_register_pointer;
    logic [7:0] sensor3_register_pointer;
    logic [7:0] sensor4_register_pointer;
    logic [2:0] sensor2_read_count;
    logic [2:0] sensor3_read_count;
    logic [2:0] sensor4_read_count;
    logic [7:0] write_or_condition_byte;
    logic       sensor1_read;
    logic       source_mode;
    logic [1:0] sensors_used;
  } hub_cfg_s;
endpackage

//--- rtl/sensor_hub_cfg.sv
// sensor hub configuration bank with trigger decimation
// assumes an AXI4-Lite master on mclk_i and an async hub trigger pin
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
module sensor_hub_cfg #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // axi write address and data
  input  wire logic [ADDR_W-1:0] axi_awaddr_i,
  input  wire logic              axi_awvalid_i,
  output logic                   axi_awready_o,
  input  wire logic [31:0]       axi_wdata_i,
  input  wire logic [3:0]        axi_wstrb_i,
  input  wire logic              axi_wvalid_i,
  output logic                   axi_wready_o,
  // axi write response
  output logic [1:0]             axi_bresp_o,
  output logic                   axi_bvalid_o,
  input  wire logic              axi_bready_i,
  // axi read
  input  wire logic [ADDR_W-1:0] axi_araddr_i,
  input  wire logic              axi_arvalid_i,
  output logic                   axi_arready_o,
  output logic [31:0]            axi_rdata_o,
  output logic [1:0]             axi_rresp_o,
  output logic                   axi_rvalid_o,
  input  wire logic              axi_rready_i,
  // hub side
  input  wire logic              trigger_i,
  input  wire logic [7:0]        cond_byte_i,
  output logic [3:0]             sensor_due_o,
  output sensor_hub_pkg::hub_cfg_s cfg_o
);

  typedef struct packed {
    logic [15:0][7:0] regs;
    logic             aw_held;
    logic [3:0]       aw_idx;
    logic             w_held;
    logic [7:0]       w_byte;
    logic             w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             trg_meta;
    logic             trg_sync;
    logic             trg_prev;
    logic [2:0][2:0]  cnt;
    logic [3:0]       due;
    logic [3:0]       last_due;
  } state_s;

  state_s     s;
  state_s     next_s;
  logic       aw_go;
  logic       w_go;
  logic       ar_go;
  logic       wr_fire;
  logic [3:0] wr_idx;
  logic [7:0] wr_byte;
  logic       wr_strb;
  logic [3:0] rd_idx;
  logic       trg_edge;
  logic [1:0] used;
  logic       s1_read;
  logic       s1_src;

  // indices software may write
  function automatic logic writable(input logic [3:0] idx);
    writable = (idx == sensor_hub_pkg::IDX_HUB_CTRL) ||
               ((idx >= sensor_hub_pkg::IDX_S2_REG) &&
                (idx <= sensor_hub_pkg::IDX_S1_BYTE));
  endfunction

  // rate code to counter mask
  function automatic logic [2:0] rate_mask(input logic [1:0] rate);
    unique case (rate)
      2'h0: rate_mask = 3'h0;
      2'h1: rate_mask = 3'h1;
      2'h2: rate_mask = 3'h3;
      2'h3: rate_mask = 3'h7;
    endcase
  endfunction

  // config register index of sensor k+2
  function automatic logic [3:0] cfg_idx(input int k);
    unique case (k)
      0:       cfg_idx = sensor_hub_pkg::IDX_S2_CFG;
      1:       cfg_idx = sensor_hub_pkg::IDX_S3_CFG;
      default: cfg_idx = sensor_hub_pkg::IDX_S4_CFG;
    endcase
  endfunction

  // handshakes and write merge
  assign axi_awready_o = !s.aw_held && !s.bvalid;
  assign axi_wready_o  = !s.w_held && !s.bvalid;
  assign axi_arready_o = !s.rvalid;
  assign aw_go   = axi_awvalid_i && axi_awready_o;
  assign w_go    = axi_wvalid_i && axi_wready_o;
  assign ar_go   = axi_arvalid_i && axi_arready_o;
  assign wr_idx  = s.aw_held ? s.aw_idx
                 : axi_awaddr_i[sensor_hub_pkg::IDX_LSB +: 4];
  assign wr_byte = s.w_held ? s.w_byte : axi_wdata_i[7:0];
  assign wr_strb = s.w_held ? s.w_strb : axi_wstrb_i[0];
  assign wr_fire = (s.aw_held || aw_go) && (s.w_held || w_go) && !s.bvalid;
  assign rd_idx  = axi_araddr_i[sensor_hub_pkg::IDX_LSB +: 4];
  assign trg_edge = s.trg_sync && !s.trg_prev;

  // hub control fields
  assign used    = s.regs[sensor_hub_pkg::IDX_HUB_CTRL]
                         [sensor_hub_pkg::CTRL_USED +: 2];
  assign s1_read = s.regs[sensor_hub_pkg::IDX_HUB_CTRL]
                         [sensor_hub_pkg::CTRL_READ];
  assign s1_src  = s.regs[sensor_hub_pkg::IDX_HUB_CTRL]
                         [sensor_hub_pkg::CTRL_SRC];

  // bus outputs from flops
  assign axi_bvalid_o = s.bvalid;
  assign axi_bresp_o  = s.bresp;
  assign axi_rvalid_o = s.rvalid;
  assign axi_rdata_o  = s.rdata;
  assign axi_rresp_o  = s.rresp;
  assign sensor_due_o = s.due;

  // configuration carried to the hub engine
  always_comb begin
    cfg_o.sensor3_target_addr =
      s.regs[sensor_hub_pkg::IDX_S3_ADDR][7:sensor_hub_pkg::ADDR_LSB];
    cfg_o.sensor4_target_addr =
      s.regs[sensor_hub_pkg::IDX_S4_ADDR][7:sensor_hub_pkg::ADDR_LSB];
    cfg_o.sensor2_register_pointer =
      s.regs[sensor_hub_pkg::IDX_S2_REG];
    cfg_o.sensor3_register_pointer =
      s.regs[sensor_hub_pkg::IDX_S3_REG];
    cfg_o.sensor4_register_pointer =
      s.regs[sensor_hub_pkg::IDX_S4_REG];
    cfg_o.sensor2_read_count = s.regs[sensor_hub_pkg::IDX_S2_CFG][2:0];
    cfg_o.sensor3_read_count = s.regs[sensor_hub_pkg::IDX_S3_CFG][2:0];
    cfg_o.sensor4_read_count = s.regs[sensor_hub_pkg::IDX_S4_CFG][2:0];
    cfg_o.write_or_condition_byte =
      s.regs[sensor_hub_pkg::IDX_S1_BYTE];
    cfg_o.sensor1_read = s1_read;
    cfg_o.source_mode  = s1_src;
    cfg_o.sensors_used = used;
  end

  // next state: bus slave, trigger sync, decimation
  always_comb begin
    next_s = s;
    if (aw_go) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = axi_awaddr_i[sensor_hub_pkg::IDX_LSB +: 4];
    end
    if (w_go) begin
      next_s.w_held = 1'b1;
      next_s.w_byte = axi_wdata_i[7:0];
      next_s.w_strb = axi_wstrb_i[0];
    end
    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = writable(wr_idx) ? sensor_hub_pkg::RESP_OKAY
                                        : sensor_hub_pkg::RESP_SLVERR;
      // middle config bits stored as written
      if (writable(wr_idx) && wr_strb) begin
        next_s.regs[wr_idx] = wr_byte;
      end
    end else if (s.bvalid && axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (ar_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = sensor_hub_pkg::RESP_OKAY;
      next_s.rdata  = 32'h0;
      if (rd_idx == sensor_hub_pkg::IDX_STATUS) begin
        next_s.rdata[7:0] = {1'b0, s.cnt[0], s.last_due};
      end else if (writable(rd_idx)) begin
        next_s.rdata[7:0] = s.regs[rd_idx];
      end else begin
        next_s.rresp = sensor_hub_pkg::RESP_SLVERR;
      end
    end else if (s.rvalid && axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    // two-flop sync then edge find
    next_s.trg_meta = trigger_i;
    next_s.trg_sync = s.trg_meta;
    next_s.trg_prev = s.trg_sync;
    next_s.due = 4'h0;
    if (trg_edge) begin
      // sensor one runs unless a source-mode read sees zero
      next_s.due[0] = !(s1_read && s1_src &&
                        (cond_byte_i == 8'h00));
      for (int k = 0; k < 3; k++) begin
        next_s.cnt[k] = s.cnt[k] + 3'h1;
        next_s.due[k+1] =
          (int'(used) >= k + 1) &&
          ((s.cnt[k] & rate_mask(s.regs[cfg_idx(k)]
             [sensor_hub_pkg::CFG_RATE_LSB +: 2])) == 3'h0);
      end
      next_s.due[2] = next_s.due[2] &&
        s.regs[sensor_hub_pkg::IDX_S3_ADDR]
              [sensor_hub_pkg::ADDR_EN_BIT];
      next_s.due[3] = next_s.due[3] &&
        s.regs[sensor_hub_pkg::IDX_S4_ADDR]
              [sensor_hub_pkg::ADDR_EN_BIT];
      next_s.last_due = next_s.due;
    end
  end

  // single state register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // bus answers hold until taken
  a_bresp_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s.bvalid && !axi_bready_i |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s.rvalid && !axi_rready_i |=> s.rvalid && $stable(s.rdata))
    else $error("read data dropped early");

  a_rate_none: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && used != 2'h0 &&
    s.regs[sensor_hub_pkg::IDX_S2_CFG][7:6] == 2'h0 |=> sensor_due_o[1])
    else $error("undecimated sensor two read missed");
  a_rate_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && s.cnt[0][0] &&
    s.regs[sensor_hub_pkg::IDX_S2_CFG][7:6] != 2'h0 |=> !sensor_due_o[1])
    else $error("decimated read not skipped");
  a_cnt_step: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge |=> s.cnt[2] == 3'($past(s.cnt[2]) + 3'h1))
    else $error("trigger counter did not step");
  a_count_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S3_CFG
    |=> cfg_o.sensor3_read_count == $past(wr_byte[2:0]))
    else $error("read count not stored");
  a_addr_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S4_ADDR
    |=> cfg_o.sensor4_target_addr == $past(wr_byte[7:1]))
    else $error("bus address not stored");
  a_s3_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && !s.regs[sensor_hub_pkg::IDX_S3_ADDR][0] |=> !sensor_due_o[2])
    else $error("disabled sensor three read");
  a_s4_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && !s.regs[sensor_hub_pkg::IDX_S4_ADDR][0] |=> !sensor_due_o[3])
    else $error("disabled sensor four read");
  a_ptr_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S3_REG
    |=> cfg_o.sensor3_register_pointer == $past(wr_byte))
    else $error("register pointer not stored");
  a_s2_ptr_read: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ar_go && rd_idx == sensor_hub_pkg::IDX_S2_REG
    |=> s.rvalid && s.rdata[7:0] == $past(s.regs[sensor_hub_pkg::IDX_S2_REG]))
    else $error("sensor two pointer read wrong");
  a_byte_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S1_BYTE
    |=> cfg_o.write_or_condition_byte == $past(wr_byte))
    else $error("write byte not stored");
  a_write_op: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && !s1_read |=> sensor_due_o[0])
    else $error("sensor one write skipped");
  a_src_abort: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && s1_read && s1_src && cond_byte_i == 8'h00
    |=> !sensor_due_o[0])
    else $error("source mode did not abort");
  a_one_sensor: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && used == 2'h0 |=> sensor_due_o[3:1] == 3'h0)
    else $error("extra sensor read with count one");

  // decimation, gating, source-mode and config write guards
  a_rate_due: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && used == 2'h3 && s.regs[sensor_hub_pkg::IDX_S4_ADDR][0] &&
    s.cnt[2] == 3'h0 |=> sensor_due_o[3])
    else $error("counter at zero but sensor four not due");
  a_rate_four: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && s.regs[sensor_hub_pkg::IDX_S3_CFG][7:6] == 2'h2 &&
    s.cnt[1][1:0] != 2'h0 |=> !sensor_due_o[2])
    else $error("sensor three read off the four ratio");
  a_due_idle: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !trg_edge |=> sensor_due_o == 4'h0)
    else $error("read due without a trigger");
  a_src_go: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && s1_read && s1_src && cond_byte_i != 8'h00
    |=> sensor_due_o[0])
    else $error("source mode read dropped on nonzero value");
  a_two_sensor: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trg_edge && used == 2'h1 |=> sensor_due_o[3:2] == 2'h0)
    else $error("extra sensor read with count two");
  a_s2_count: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S2_CFG
    |=> cfg_o.sensor2_read_count == $past(wr_byte[2:0]))
    else $error("sensor two read count not stored");
  a_s3_addr: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S3_ADDR
    |=> cfg_o.sensor3_target_addr == $past(wr_byte[7:1]))
    else $error("sensor three bus address not stored");
  a_s4_ptr: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && wr_strb && wr_idx == sensor_hub_pkg::IDX_S4_REG
    |=> cfg_o.sensor4_register_pointer == $past(wr_byte))
    else $error("sensor four register pointer not stored");

  // bus refusals and strobe-less writes leave the bank untouched
  a_bad_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && !writable(wr_idx)
    |=> s.bresp == sensor_hub_pkg::RESP_SLVERR && $stable(s.regs))
    else $error("unmapped write accepted");
  a_strb_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && !wr_strb |=> $stable(s.regs))
    else $error("write without strobe changed a register");
  a_bad_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ar_go && rd_idx != sensor_hub_pkg::IDX_STATUS && !writable(rd_idx)
    |=> s.rresp == sensor_hub_pkg::RESP_SLVERR && s.rdata == 32'h0)
    else $error("unmapped read not refused");

endmodule

//--- dv/hub_far_side.sv
// far-side model: hub trigger source and condition register
// assumes the bench pulses go_i for one mclk cycle with n_i set
`timescale 1ns/1ns
module hub_far_side (
  // control from the bench
  input  wire logic       go_i,
  input  wire logic [7:0] n_i,
  input  wire logic [7:0] cond_i,
  // toward the block
  output logic            trig_o,
  output logic [7:0]      cond_o
);
  // value of the register read first in source mode
  assign cond_o = cond_i;
  // bursts at the 32 ns link rate, trigger low between bursts
  initial begin
    trig_o = 1'b0;
    forever begin
      @(posedge go_i);
      #1;
      repeat (n_i) begin
        #16 trig_o = 1'b1;
        #16 trig_o = 1'b0;
      end
    end
  end
endmodule

//--- dv/sensor_hub_cfg_test.sv
// self-checking bench for the hub config bank
// assumes the far-side model drives trigger and condition byte
`timescale 1ns/1ns
module sensor_hub_cfg_test;
  localparam logic [1:0] OK = sensor_hub_pkg::RESP_OKAY;
  localparam logic [1:0] ER = sensor_hub_pkg::RESP_SLVERR;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  axi_awaddr_i = 8'h00, axi_araddr_i = 8'h00;
  logic [31:0] axi_wdata_i = 32'h0;
  logic [3:0]  axi_wstrb_i = 4'h0;
  logic        axi_awvalid_i = 1'b0, axi_wvalid_i = 1'b0;
  logic        axi_bready_i = 1'b0, axi_arvalid_i = 1'b0;
  logic        axi_rready_i = 1'b0, go = 1'b0;
  logic [7:0]  n_trig = 8'h00, cond = 8'h00, cond_byte_i;
  logic        trigger_i, axi_awready_o, axi_wready_o, axi_bvalid_o;
  logic        axi_arready_o, axi_rvalid_o;
  logic [1:0]  axi_bresp_o, axi_rresp_o;
  logic [31:0] axi_rdata_o;
  logic [3:0]  sensor_due_o;
  sensor_hub_pkg::hub_cfg_s cfg_o;
  int          n_fail = 0, tests_run = 0;
  int          due_n[4] = '{0, 0, 0, 0};
  logic [7:0]  ra[9] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c,
                         8'h30, 8'h34, 8'h38};
  logic [7:0]  rd[9] = '{8'h3c, 8'hc5, 8'ha3, 8'h96, 8'h47, 8'hd9,
                         8'he1, 8'h82, 8'h5a};

  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;

  sensor_hub_cfg u_dut (.mclk_i, .rst_n_i, .axi_awaddr_i, .axi_awvalid_i,
    .axi_awready_o, .axi_wdata_i, .axi_wstrb_i, .axi_wvalid_i,
    .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i,
    .axi_araddr_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o,
    .axi_rresp_o, .axi_rvalid_o, .axi_rready_i, .trigger_i, .cond_byte_i,
    .sensor_due_o, .cfg_o);
  hub_far_side u_far (.go_i(go), .n_i(n_trig), .cond_i(cond),
    .trig_o(trigger_i), .cond_o(cond_byte_i));

  // count due pulses per sensor
  always @(posedge mclk_i) begin
    for (int k = 0; k < 4; k++)
      if (sensor_due_o[k] === 1'b1) due_n[k] <= due_n[k] + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // one write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    axi_awaddr_i <= a;
    axi_wdata_i <= {24'h0, d};
    axi_wstrb_i <= s;
    axi_awvalid_i <= 1'b1;
    axi_wvalid_i <= 1'b1;
    axi_bready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (axi_awvalid_i && axi_awready_o) axi_awvalid_i <= 1'b0;
      if (axi_wvalid_i && axi_wready_o) axi_wvalid_i <= 1'b0;
      if (axi_bvalid_o === 1'b1) begin
        r = axi_bresp_o;
        break;
      end
    end
    axi_bready_i <= 1'b0;
    @(posedge mclk_i);
    chk(r, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er);
    logic [1:0]  r;
    logic [31:0] d;
    axi_araddr_i <= a;
    axi_arvalid_i <= 1'b1;
    axi_rready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (axi_arvalid_i && axi_arready_o) axi_arvalid_i <= 1'b0;
      if (axi_rvalid_o === 1'b1) begin
        r = axi_rresp_o;
        d = axi_rdata_o;
        break;
      end
    end
    axi_rready_i <= 1'b0;
    @(posedge mclk_i);
    chk(d, {24'h0, e});
    chk(r, er);
  endtask

  // eight triggers, config untouched meanwhile
  task automatic fire_chk(input int e0, input int e1, input int e2,
                          input int e3);
    int b[4];
    b = due_n;
    n_trig <= 8'd8;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (100) @(posedge mclk_i);
    chk(due_n[0] - b[0], e0);
    chk(due_n[1] - b[1], e1);
    chk(due_n[2] - b[2], e2);
    chk(due_n[3] - b[3], e3);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rdc(ra[i], 8'h00, OK);
    rdc(8'h38, 8'h00, OK);
    rdc(8'h08, 8'h00, ER);
    wr(8'h08, 8'h11, 4'h1, ER);
    wr(8'h00, 8'h11, 4'h1, ER);
    $display("test reset done");
  endtask

  task automatic t_rw;
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rd[i], 4'h1, OK);
      rdc(ra[i], rd[i], OK);
    end
    wr(ra[0], 8'hff, 4'h0, OK);
    rdc(ra[0], rd[0], OK);
    chk(cfg_o.sensor2_register_pointer, rd[0]);
    chk(cfg_o.sensor2_read_count, rd[1][2:0]);
    chk(cfg_o.sensor3_target_addr, rd[2][7:1]);
    chk(cfg_o.sensor3_register_pointer, rd[3]);
    chk(cfg_o.sensor3_read_count, rd[4][2:0]);
    chk(cfg_o.sensor4_target_addr, rd[5][7:1]);
    chk(cfg_o.sensor4_register_pointer, rd[6]);
    chk(cfg_o.sensor4_read_count, rd[7][2:0]);
    chk(cfg_o.write_or_condition_byte, rd[8]);
    $display("test readwrite done");
  endtask

  task automatic t_rate;
    wr(8'h04, 8'h30, 4'h1, OK);
    for (int r = 0; r < 4; r++) begin
      wr(8'h1c, {r[1:0], 6'h05}, 4'h1, OK); // middle zero
      wr(8'h28, {r[1:0], 6'h05}, 4'h1, OK);
      wr(8'h34, {r[1:0], 6'h05}, 4'h1, OK);
      fire_chk(8, 8 >> r, 8 >> r, 8 >> r);
    end
    $display("test decimation done");
  endtask

  task automatic t_enable;
    wr(8'h04, 8'h00, 4'h1, OK);
    fire_chk(8, 0, 0, 0);
    wr(8'h04, 8'h10, 4'h1, OK);
    fire_chk(8, 1, 0, 0);
    wr(8'h04, 8'h30, 4'h1, OK);
    wr(8'h20, 8'ha2, 4'h1, OK);
    fire_chk(8, 1, 0, 1);
    wr(8'h2c, 8'hd8, 4'h1, OK);
    wr(8'h20, 8'ha3, 4'h1, OK);
    fire_chk(8, 1, 1, 0);
    $display("test enable done");
  endtask

  task automatic t_source;
    wr(8'h04, 8'h39, 4'h1, OK);
    chk(cfg_o.sensor1_read, 1'b1);
    chk(cfg_o.source_mode, 1'b1);
    chk(cfg_o.sensors_used, 2'h3);
    fire_chk(0, 1, 1, 0);
    cond <= 8'h5a;
    fire_chk(8, 1, 1, 0);
    wr(8'h04, 8'h38, 4'h1, OK);
    cond <= 8'h00;
    fire_chk(8, 1, 1, 0);
    rdc(8'h00, 8'h01, OK);
    $display("test source done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset;
    t_rw;
    t_rate;
    t_enable;
    t_source;
    test_done;
  end

  // watchdog
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule
